// ---- verilog/bml_consts.svh ----
// Constants for the byte move load decoder: opcodes, flag layout, counts.
// Assumes nothing; included by the package and the design files.
`ifndef BML_CONSTS_SVH
`define BML_CONSTS_SVH

// ==========================================================================
// Opcode nibble, instrWord[15:12]
`define BML_OP_IMM    4'h1
`define BML_OP_REG    4'h2
`define BML_OP_IND    4'h3
`define BML_OP_DISP   4'h4
`define BML_OP_POST   4'h5
`define BML_OP_ABS8   4'h6
`define BML_OP_ABS16  4'h7

// ==========================================================================
// Flag register bit positions and reset value
`define BML_FLAG_I      7
`define BML_FLAG_H      5
`define BML_FLAG_N      3
`define BML_FLAG_Z      2
`define BML_FLAG_V      1
`define BML_FLAG_C      0
`define BML_FLAG_RESET  8'h00

// ==========================================================================
// Upper address byte of the short absolute form
`define BML_ABS8_PAGE   8'hff

// ==========================================================================
// State counts and instruction lengths in bytes
`define BML_ST_IMM    3'h2
`define BML_ST_REG    3'h2
`define BML_ST_IND    3'h4
`define BML_ST_DISP   3'h6
`define BML_ST_POST   3'h6
`define BML_ST_ABS8   3'h4
`define BML_ST_ABS16  3'h6
`define BML_ST_BAD    3'h2
`define BML_LEN_SHORT 3'h2
`define BML_LEN_LONG  3'h4

`endif

// ---- verilog/bml_pkg.sv ----
// Types and decode functions of the byte move load decoder.
// Assumes bml_consts.svh is on the include path.
`include "bml_consts.svh"

package bml_pkg;

  // ========================================================================
  // Addressing modes
  typedef enum logic [2:0] {
    BML_M_BAD, BML_M_IMM, BML_M_REG, BML_M_IND,
    BML_M_DISP, BML_M_POST, BML_M_ABS8, BML_M_ABS16
  } bml_mode_t;

  function automatic bml_mode_t bml_decode_mode(input logic [3:0] op);
    unique case (op)
      `BML_OP_IMM:   bml_decode_mode = BML_M_IMM;
      `BML_OP_REG:   bml_decode_mode = BML_M_REG;
      `BML_OP_IND:   bml_decode_mode = BML_M_IND;
      `BML_OP_DISP:  bml_decode_mode = BML_M_DISP;
      `BML_OP_POST:  bml_decode_mode = BML_M_POST;
      `BML_OP_ABS8:  bml_decode_mode = BML_M_ABS8;
      `BML_OP_ABS16: bml_decode_mode = BML_M_ABS16;
      default:       bml_decode_mode = BML_M_BAD;
    endcase
  endfunction

  function automatic logic [2:0] bml_states(input bml_mode_t m);
    unique case (m)
      BML_M_IMM:   bml_states = `BML_ST_IMM;
      BML_M_REG:   bml_states = `BML_ST_REG;
      BML_M_IND:   bml_states = `BML_ST_IND;
      BML_M_DISP:  bml_states = `BML_ST_DISP;
      BML_M_POST:  bml_states = `BML_ST_POST;
      BML_M_ABS8:  bml_states = `BML_ST_ABS8;
      BML_M_ABS16: bml_states = `BML_ST_ABS16;
      BML_M_BAD:   bml_states = `BML_ST_BAD;
    endcase
  endfunction

  function automatic logic bml_has_ext(input bml_mode_t m);
    bml_has_ext = (m == BML_M_DISP) || (m == BML_M_ABS16);
  endfunction

  function automatic logic bml_reads_mem(input bml_mode_t m);
    bml_reads_mem = (m != BML_M_BAD) && (m != BML_M_IMM) && (m != BML_M_REG);
  endfunction

endpackage

// ---- verilog/bml_flags.sv ----
// Flag register update for a byte moved into a register.
// Assumes the caller loads the result into the flag register.
`include "bml_consts.svh"

module bml_flags (
  input  wire logic [7:0] baseFlags,
  input  wire logic [7:0] moveVal,
  input  wire logic       apply,
  output logic      [7:0] newFlags
);
  import bml_pkg::*;

  logic [7:0] moved;

  always_comb begin
    moved                = baseFlags;
    moved[`BML_FLAG_N]   = moveVal[7];
    moved[`BML_FLAG_Z]   = (moveVal == 8'h00);
    moved[`BML_FLAG_V]   = 1'b0;
    newFlags             = apply ? moved : baseFlags;
  end

endmodule // bml_flags

// ---- verilog/bml_decode.sv ----
// Byte move load decoder: executes byte moves into a general register.
// Assumes memory and fetch answer exactly one cycle after a request, the
// register file read port is combinational, and all inputs share sys_clk.
// Behaviour
// - N copies bit 7 of the moved byte, Z set when it is zero.
// - Every byte move clears the overflow flag.
// - Carry, interrupt mask and half-carry keep their previous values.
// - Immediate move: two bytes, constant to destination, two states.
// - Register move: source byte to destination, two bytes, two states.
// - Indirect load: 16-bit pointer as address, two bytes, four states.
// - Displacement load: pointer plus 16-bit displacement, four bytes, six states.
// - Post-increment load: read at pointer, then pointer plus one, six states.
// - Absolute loads: short form 2 bytes/4 states, long 4 bytes/6 states.
`include "bml_consts.svh"

module bml_decode (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  output logic             instrReady,
  output logic             fetchReq,
  input  wire logic [15:0] fetchData,
  output logic      [2:0]  regRdIdx,
  input  wire logic [15:0] regRdData,
  output logic             memRd,
  output logic      [15:0] memAddr,
  input  wire logic [7:0]  memData,
  output logic             regWrEn,
  output logic      [3:0]  regWrIdx,
  output logic      [7:0]  regWrData,
  output logic             ptrWrEn,
  output logic      [2:0]  ptrWrIdx,
  output logic      [15:0] ptrWrData,
  input  wire logic        flagLoad,
  input  wire logic [7:0]  flagLoadData,
  output logic      [7:0]  flagReg,
  output logic             retire,
  output logic      [2:0]  retireLen
);
  import bml_pkg::*;

  // ========================================================================
  // Instruction state
  logic            busy;
  logic     [2:0]  cnt;
  bml_mode_t       mode;
  logic     [3:0]  dst;
  logic     [7:0]  lit;
  logic     [15:0] ext;
  logic     [15:0] ptr;

  // ========================================================================
  // Decode and selection
  wire             accept    = instrValid && instrReady;
  wire bml_mode_t  inMode    = bml_decode_mode(instrWord[15:12]);
  wire      [2:0]  total     = bml_states(mode);
  wire             lastCyc   = busy && (cnt == total - 3'h1);
  wire             doneCyc   = busy && (cnt == total);
  // Pointer is only latched at the end of cycle 1; read it straight through then
  wire      [15:0] srcPair   = (cnt == 3'h1) ? regRdData : ptr;
  wire      [7:0]  srcByte   = lit[7] ? srcPair[7:0] : srcPair[15:8];
  wire      [15:0] dispAddr  = srcPair + ext;
  wire      [15:0] abs8Addr  = {`BML_ABS8_PAGE, lit};
  wire             memIssue  = busy && bml_reads_mem(mode) && (cnt == total - 3'h3);
  wire             writeNow  = lastCyc && (mode != BML_M_BAD);
  wire             postNow   = busy && (mode == BML_M_POST) && (cnt == total - 3'h2);
  wire      [7:0]  baseFlags = flagLoad ? flagLoadData : flagReg;
  wire      [7:0]  next_flags;
  logic     [15:0] next_addr;
  logic     [7:0]  next_val;
  logic     [2:0]  next_len;

  always_comb begin
    unique case (mode)
      BML_M_DISP:  next_addr = dispAddr;
      BML_M_ABS8:  next_addr = abs8Addr;
      BML_M_ABS16: next_addr = ext;
      default:     next_addr = srcPair;
    endcase
  end

  always_comb begin
    unique case (mode)
      BML_M_IMM: next_val = lit;
      BML_M_REG: next_val = srcByte;
      default:   next_val = memData;
    endcase
  end

  always_comb begin
    next_len = bml_has_ext(mode) ? `BML_LEN_LONG : `BML_LEN_SHORT;
  end

  bml_flags u_flags (
    .baseFlags (baseFlags),
    .moveVal   (next_val),
    .apply     (writeNow),
    .newFlags  (next_flags)
  );

  // ========================================================================
  // Sequencing: cycle 0 takes the instruction, the write lands in cycle N
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      cnt        <= 3'h0;
      instrReady <= 1'b1;
    end else begin
      busy       <= accept ? 1'b1 : (doneCyc ? 1'b0 : busy);
      cnt        <= accept ? 3'h1 : (busy ? cnt + 3'h1 : cnt);
      instrReady <= accept ? 1'b0 : (lastCyc ? 1'b1 : instrReady);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode     <= BML_M_BAD;
      dst      <= 4'h0;
      lit      <= 8'h00;
      regRdIdx <= 3'h0;
      fetchReq <= 1'b0;
    end else begin
      fetchReq <= accept && bml_has_ext(inMode);
      if (accept) begin
        mode     <= inMode;
        dst      <= instrWord[11:8];
        lit      <= instrWord[7:0];
        regRdIdx <= instrWord[6:4];
      end
    end
  end

  // Extension word arrives in cycle 2, latched just in time for the operand address formed in cycle 3
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext <= 16'h0000;
      ptr <= 16'h0000;
    end else begin
      if (busy && (cnt == 3'h2) && bml_has_ext(mode))
        ext <= fetchData;
      if (busy && (cnt == 3'h1))
        ptr <= regRdData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      memRd   <= 1'b0;
      memAddr <= 16'h0000;
    end else begin
      memRd <= memIssue;
      if (memIssue)
        memAddr <= next_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptrWrEn   <= 1'b0;
      ptrWrIdx  <= 3'h0;
      ptrWrData <= 16'h0000;
    end else begin
      ptrWrEn <= postNow;
      if (postNow) begin
        ptrWrIdx  <= regRdIdx;
        ptrWrData <= ptr + 16'h0001;
      end
    end
  end

  // Retire and register write share one cycle, so retire never precedes it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regWrEn   <= 1'b0;
      regWrIdx  <= 4'h0;
      regWrData <= 8'h00;
      retire    <= 1'b0;
      retireLen <= 3'h0;
      flagReg   <= `BML_FLAG_RESET;
    end else begin
      regWrEn <= writeNow;
      retire  <= lastCyc;
      flagReg <= next_flags;
      if (lastCyc) begin
        regWrIdx  <= dst;
        regWrData <= next_val;
        retireLen <= next_len;
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_flag_nz: assert property (regWrEn |-> (flagReg[`BML_FLAG_N] == regWrData[7]) &&
      (flagReg[`BML_FLAG_Z] == (regWrData == 8'h00)))
    else $error("N or Z flag wrong after byte move");
  chk_flag_v: assert property (regWrEn |-> !flagReg[`BML_FLAG_V])
    else $error("V flag not cleared by byte move");
  chk_flag_keep: assert property (regWrEn && !$past(flagLoad) |->
      (flagReg[`BML_FLAG_C] == $past(flagReg[`BML_FLAG_C])) &&
      (flagReg[`BML_FLAG_I] == $past(flagReg[`BML_FLAG_I])) &&
      (flagReg[`BML_FLAG_H] == $past(flagReg[`BML_FLAG_H])))
    else $error("C, I or H flag disturbed by byte move");
  chk_imm_move: assert property (accept && inMode == BML_M_IMM |->
      ##2 (regWrEn && retire && retireLen == 3'h2 && regWrData == $past(instrWord[7:0], 2)))
    else $error("Immediate move wrong value or timing");
  // Back to back, the previous write may still stand in the accept cycle
  chk_reg_move: assert property (accept && inMode == BML_M_REG |->
      ##1 (!regWrEn && !memRd && !retire) ##1 (regWrEn && retire && retireLen == 3'h2))
    else $error("Register move timing wrong");
  chk_ind_load: assert property (accept && inMode == BML_M_IND |->
      ##1 1'b1 ##1 (memRd && memAddr == $past(regRdData)) ##2
      (regWrEn && regWrData == $past(memData)))
    else $error("Indirect load address or timing wrong");
  chk_disp_load: assert property (accept && inMode == BML_M_DISP |->
      ##4 (memRd && memAddr == $past(ptr) + $past(ext)) ##2 (regWrEn && retireLen == 3'h4))
    else $error("Displacement load address or timing wrong");
  chk_post_inc: assert property (accept && inMode == BML_M_POST |->
      ##4 memRd ##1 (ptrWrEn && ptrWrData == $past(memAddr) + 16'h0001) ##1 regWrEn)
    else $error("Post-increment load wrong");
  chk_abs8_load: assert property (accept && inMode == BML_M_ABS8 |->
      ##2 (memRd && memAddr[15:8] == `BML_ABS8_PAGE) ##2 (regWrEn && retireLen == 3'h2))
    else $error("Short absolute load wrong");
  chk_abs16_load: assert property (accept && inMode == BML_M_ABS16 |->
      ##6 (regWrEn && retireLen == 3'h4))
    else $error("Long absolute load timing wrong");
  chk_ext_first: assert property (fetchReq |-> !memRd ##1 !memRd ##1 !memRd)
    else $error("Operand read before extension fetched");
  chk_retire_write: assert property (regWrEn |-> retire)
    else $error("Register written without retire");

  cov_imm:  cover property (accept && inMode == BML_M_IMM ##2 regWrEn);
  cov_disp: cover property (accept && inMode == BML_M_DISP ##6 regWrEn);
  cov_post: cover property (ptrWrEn ##1 regWrEn);
  cov_b2b:  cover property (retire && accept);
  cov_load_merge: cover property (flagLoad && writeNow);

endmodule // bml_decode

// ---- sim/bml_mem_model.sv ----
// Memory and extension-fetch responder for the byte move load decoder bench.
// Assumes the decoder samples answers one cycle after each request pulse.
module bml_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        memRd,
  input  wire logic [15:0] memAddr,
  input  wire logic        fetchReq,
  input  wire logic [15:0] extWord,
  output logic      [7:0]  memData,
  output logic      [15:0] fetchData
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Content and answers
  // Content mixes both address bytes, so a wrong upper byte reads differently
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[15:8] ^ {a[6:0], a[7]} ^ 8'h3c;
  endfunction

  initial begin
    memData = 8'h00;
    fetchData = 16'h0000;
  end

  // Idle bus inverts each cycle, so a late sample never sees stale data
  always @(posedge sys_clk) begin
    memData <= memRd ? mem_byte(memAddr) : ~memData;
    fetchData <= fetchReq ? extWord : ~fetchData;
  end
endmodule // bml_mem_model

// ---- sim/byte_move_load_decode_tb.sv ----
// Self-checking bench for the byte move load decoder.
// Assumes bml_pkg, bml_decode and bml_mem_model are compiled before it.
`include "bml_consts.svh"

module byte_move_load_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic        flagLoad = 1'b0;
  logic [7:0]  flagLoadData = 8'h00;
  logic [15:0] extWord = 16'h0000;
  logic        instrReady, fetchReq, memRd, regWrEn, ptrWrEn, retire;
  logic [2:0]  regRdIdx, ptrWrIdx, retireLen;
  logic [15:0] regRdData, fetchData, memAddr, ptrWrData;
  logic [7:0]  memData, regWrData, flagReg;
  logic [3:0]  regWrIdx;
  logic [15:0] regFile [8];
  logic [7:0]  expFlags = 8'h00;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  assign regRdData = regFile[regRdIdx];

  bml_decode u_bml_decode (.sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .fetchReq(fetchReq),
    .fetchData(fetchData), .regRdIdx(regRdIdx), .regRdData(regRdData), .memRd(memRd),
    .memAddr(memAddr), .memData(memData), .regWrEn(regWrEn), .regWrIdx(regWrIdx),
    .regWrData(regWrData), .ptrWrEn(ptrWrEn), .ptrWrIdx(ptrWrIdx), .ptrWrData(ptrWrData),
    .flagLoad(flagLoad), .flagLoadData(flagLoadData), .flagReg(flagReg),
    .retire(retire), .retireLen(retireLen));

  bml_mem_model u_bml_mem_model (.sys_clk(sys_clk), .memRd(memRd), .memAddr(memAddr),
    .fetchReq(fetchReq), .extWord(extWord), .memData(memData), .fetchData(fetchData));

  // ==========================================================================
  // Clock, watchdog, reporting
  always #20 sys_clk = ~sys_clk;

  // Whole run is about 1000 cycles; the ceiling leaves generous room
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      $display("mismatch at %0t: run timed out", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic load_flags(input logic [7:0] f);
    @(posedge sys_clk);
    flagLoad <= 1'b1;
    flagLoadData <= f;
    @(posedge sys_clk);
    flagLoad <= 1'b0;
    expFlags = f;
  endtask

  // ==========================================================================
  // One instruction against the reference model
  task automatic run_op(input logic [3:0] op, input logic [3:0] dst, input logic [7:0] lit,
                        input logic [15:0] ext);
    logic [2:0]  src = lit[6:4];
    logic [15:0] addr = regFile[lit[6:4]];
    logic [7:0]  v = lit;
    int          n = 0;
    int          want = 2;
    bit          good = 1;
    bit          ldm = 0;
    bit          hasExt = 0;
    bit          fetched = 0;
    bit          sawRd = 0;
    bit          sawPtr = 0;
    extWord = ext;
    case (op)
      `BML_OP_IMM: ;
      `BML_OP_REG: v = lit[7] ? addr[7:0] : addr[15:8];
      `BML_OP_IND: begin want = 4; ldm = 1; end
      `BML_OP_DISP: begin want = 6; ldm = 1; hasExt = 1; addr = addr + ext; end
      `BML_OP_POST: begin want = 6; ldm = 1; end
      `BML_OP_ABS8: begin want = 4; ldm = 1; addr = {8'hff, lit}; end
      `BML_OP_ABS16: begin want = 6; ldm = 1; hasExt = 1; addr = ext; end
      default: good = 0;
    endcase
    if (ldm) v = u_bml_mem_model.mem_byte(addr);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord <= {op, dst, lit};
    do @(posedge sys_clk); while (instrReady !== 1'b1);
    instrValid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      if (fetchReq === 1'b1) fetched = 1;
      if (memRd === 1'b1) begin
        sawRd = 1;
        chk(memAddr, addr, "operand address");
        chk(16'(fetched), 16'(hasExt), "extension before read");
      end
      if (ptrWrEn === 1'b1) begin
        sawPtr = 1;
        chk({13'h0, ptrWrIdx}, 16'(src), "pointer index");
        chk(ptrWrData, addr + 16'h0001, "pointer increment");
      end
    end while (retire !== 1'b1 && n < 12);
    chk(16'(n), 16'(want), "state count");
    chk({13'h0, retireLen}, hasExt ? 16'h4 : 16'h2, "length");
    chk(16'(sawRd), 16'(ldm), "operand read");
    chk(16'(sawPtr), 16'(op == `BML_OP_POST), "pointer write-back");
    chk({15'h0, regWrEn}, 16'(good), "write with retire");
    if (good) begin
      expFlags[`BML_FLAG_N] = v[7];
      expFlags[`BML_FLAG_Z] = (v == 8'h00);
      expFlags[`BML_FLAG_V] = 1'b0;
      chk({12'h0, regWrIdx}, 16'(dst), "destination");
      chk({8'h0, regWrData}, 16'(v), "moved byte");
      if (op == `BML_OP_POST) regFile[src] = addr + 16'h0001;
      if (dst[3]) regFile[dst[2:0]][7:0] = v;
      else regFile[dst[2:0]][15:8] = v;
    end
    chk({8'h0, flagReg}, {8'h0, expFlags}, "flag register");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(28));
    foreach (regFile[i]) regFile[i] = 16'($urandom);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk({15'h0, instrReady}, 16'h0001, "ready after reset");
    chk({8'h0, flagReg}, 16'h0000, "flags after reset");
    $display("test reset done");
    // Zero and negative bytes, then every opcode; pointer at ffff wraps
    load_flags(8'hff);
    run_op(`BML_OP_IMM, 4'h9, 8'h00, 16'h0000);
    run_op(`BML_OP_IMM, 4'h2, 8'h80, 16'h0000);
    regFile[3] = 16'hffff;
    for (int k = 2; k < 9; k++)
      run_op(k == 8 ? 4'hf : 4'(k), 4'(k + 5), 8'hb0, 16'h8001);
    $display("test opcodes done");
    for (int k = 0; k < 150; k++) begin
      if (k % 8 == 0) load_flags(8'($urandom));
      run_op(4'($urandom_range(0, 8)), 4'($urandom), 8'($urandom), 16'($urandom));
    end
    $display("test random done");
    // Back to back, with a flag load landing in the immediate's compute cycle
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord <= {`BML_OP_IMM, 4'h8, 8'h5a};
    @(posedge sys_clk);
    instrWord <= {`BML_OP_REG, 4'h3, 8'h90};
    flagLoad <= 1'b1;
    flagLoadData <= 8'ha3;
    @(posedge sys_clk);
    flagLoad <= 1'b0;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    chk({14'h0, retire, instrReady}, 16'h0003, "retire with ready");
    chk({8'h0, regWrData}, 16'h005a, "first of pair");
    chk({8'h0, flagReg}, 16'h00a1, "loaded flags overlaid");
    regFile[0][7:0] = 8'h5a;
    expFlags = 8'ha3;
    expFlags[`BML_FLAG_N] = regFile[1][7];
    expFlags[`BML_FLAG_Z] = (regFile[1][7:0] == 8'h00);
    expFlags[`BML_FLAG_V] = 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({15'h0, retire}, 16'h0001, "second retire");
    chk({12'h0, regWrIdx}, 16'h0003, "second destination");
    chk({8'h0, regWrData}, {8'h0, regFile[1][7:0]}, "second of pair");
    chk({8'h0, flagReg}, {8'h0, expFlags}, "flags after pair");
    regFile[3][15:8] = regFile[1][7:0];
    $display("test back to back done");
    print_verdict();
  end
endmodule // byte_move_load_decode_tb
